// ### boot_space_select_loader.sv
// module: boot space selection at reset and serial loader session control
// assumes: the two rx byte streams come from receivers on clk; bank first
// words and option bit are supplied by the flash array as stable levels
`timescale 1ns/1ps

module boot_space_select_loader #(
   parameter bit SILENT_ABORT = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic primary_boot_pin,
   input wire logic secondary_boot_pin,
   input wire logic [7:0] user_option_byte,
   input wire logic [1:0] prot_level_in,
   input wire logic [31:0] bank1_first_word,
   input wire logic [31:0] bank2_first_word,
   input wire logic port_one_rx_valid,
   input wire logic [7:0] port_one_rx_data,
   input wire logic port_two_rx_valid,
   input wire logic [7:0] port_two_rx_data,
   input wire logic baud_done,
   input wire logic [31:0] cmd_addr,
   input wire logic [7:0] cmd_count_m1,
   output logic [2:0] boot_space,
   output logic cpu_halt,
   output logic loader_active,
   output logic port_one_enable,
   output logic port_two_enable,
   output logic baud_start,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic mem_op_valid,
   output logic [2:0] mem_op,
   output logic [31:0] mem_addr,
   output logic [1:0] prot_level_out
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] pin_meta_r, pin_sync_r;
   always_ff @(posedge clk) begin
      pin_meta_r <= {secondary_boot_pin, primary_boot_pin};
      pin_sync_r <= pin_meta_r;
   end

   // ------------------------------------------------------------
   // boot decision
   // ------------------------------------------------------------
   logic captured_r, captured_nxt;
   boot_sel_pkg::boot_space_t space_r, space_nxt;
   logic halt_r, halt_nxt;
   logic b1_valid, b2_valid, bit_two, lvl2;

   always_comb begin
      b1_valid = bank1_first_word >= boot_sel_pkg::SRAM_LO
         && bank1_first_word <= boot_sel_pkg::SRAM_HI;
      b2_valid = bank2_first_word >= boot_sel_pkg::SRAM_LO
         && bank2_first_word <= boot_sel_pkg::SRAM_HI;
      bit_two = user_option_byte[boot_sel_pkg::BANK_TWO_BIT_POS];
      lvl2 = prot_level_in == boot_sel_pkg::PROT_L2;
      captured_nxt = 1'b1;
      space_nxt = space_r;
      halt_nxt = halt_r;
      if (!captured_r) begin
         halt_nxt = 1'b0;
         if (bit_two) begin
            if (!pin_sync_r[0] || lvl2)
               space_nxt = boot_sel_pkg::SPACE_BANK1;
            else if (!pin_sync_r[1])
               space_nxt = boot_sel_pkg::SPACE_SYSMEM;
            else
               space_nxt = boot_sel_pkg::SPACE_SRAM;
         end else if (!pin_sync_r[0] || lvl2) begin
            if (b2_valid)
               space_nxt = boot_sel_pkg::SPACE_BANK2;
            else if (b1_valid)
               space_nxt = boot_sel_pkg::SPACE_BANK1;
            else begin
               space_nxt = boot_sel_pkg::SPACE_SYSMEM;
               halt_nxt = lvl2;
            end
         end else if (!pin_sync_r[1])
            space_nxt = boot_sel_pkg::SPACE_SYSMEM;
         else
            space_nxt = boot_sel_pkg::SPACE_SRAM;
      end
   end

   // two cycles after release the pin sync stages hold real levels
   logic [1:0] settle_r, settle_nxt;
   always_comb settle_nxt = settle_r == 2'h2 ? settle_r : settle_r + 2'h1;

   always_ff @(posedge clk) begin
      if (rst) begin
         settle_r <= 2'h0;
         captured_r <= 1'b0;
         space_r <= boot_sel_pkg::SPACE_BANK1;
         halt_r <= 1'b0;
      end else begin
         settle_r <= settle_nxt;
         if (settle_r == 2'h2) begin
            captured_r <= captured_nxt;
            space_r <= space_nxt;
            halt_r <= halt_nxt;
         end
      end
   end

   // ------------------------------------------------------------
   // loader session state machine
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_DETECT = 7'b0000010,
      ST_BAUD = 7'b0000100,
      ST_CMD = 7'b0001000,
      ST_CHK = 7'b0010000,
      ST_ADDR = 7'b0100000,
      ST_MEM = 7'b1000000
   } ld_state_t;

   ld_state_t st_r, st_nxt;
   logic sel_two_r, sel_two_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic [1:0] prot_r, prot_nxt;
   logic prot_init_r, prot_init_nxt;
   logic data_prog_r, data_prog_nxt;
   logic [31:0] prog_addr_r, prog_addr_nxt;
   logic rx_v;
   logic [7:0] rx_d;
   logic known_cmd, acc_sup, acc_align, acc_data, acc_flash, is_wr;

   access_check u_access (
      .addr(cmd_addr),
      .count_m1(cmd_count_m1),
      .is_write(is_wr),
      .supported(acc_sup),
      .aligned_ok(acc_align),
      .in_data(acc_data),
      .in_flash(acc_flash)
   );

   always_comb begin
      st_nxt = st_r;
      sel_two_nxt = sel_two_r;
      cmd_nxt = cmd_r;
      prot_nxt = prot_r;
      prot_init_nxt = 1'b1;
      data_prog_nxt = 1'b0;
      baud_start = 1'b0;
      tx_valid = 1'b0;
      tx_data = boot_sel_pkg::ACK_BYTE;
      mem_op_valid = 1'b0;
      mem_op = boot_sel_pkg::MOP_NONE;
      mem_addr = cmd_addr;
      is_wr = cmd_r == boot_sel_pkg::CMD_WRITE;
      if (!prot_init_r)
         prot_nxt = prot_level_in;
      // only the chosen port is heard once selected
      rx_v = sel_two_r ? port_two_rx_valid : port_one_rx_valid;
      rx_d = sel_two_r ? port_two_rx_data : port_one_rx_data;
      case (cmd_r)
         boot_sel_pkg::CMD_GET, boot_sel_pkg::CMD_GET_VER,
         boot_sel_pkg::CMD_GET_ID, boot_sel_pkg::CMD_READ,
         boot_sel_pkg::CMD_GO, boot_sel_pkg::CMD_WRITE,
         boot_sel_pkg::CMD_ERASE, boot_sel_pkg::CMD_EXT_ERASE,
         boot_sel_pkg::CMD_WR_PROT, boot_sel_pkg::CMD_WR_UNPROT,
         boot_sel_pkg::CMD_RD_PROT, boot_sel_pkg::CMD_RD_UNPROT:
            known_cmd = 1'b1;
         default: known_cmd = 1'b0;
      endcase
      case (st_r)
         ST_IDLE: begin
            if (captured_r && space_r == boot_sel_pkg::SPACE_SYSMEM
                  && !halt_r)
               st_nxt = ST_DETECT;
         end
         ST_DETECT: begin
            if (port_one_rx_valid
                  && port_one_rx_data == boot_sel_pkg::SYNC_BYTE) begin
               sel_two_nxt = 1'b0;
               baud_start = 1'b1;
               st_nxt = ST_BAUD;
            end else if (port_two_rx_valid
                  && port_two_rx_data == boot_sel_pkg::SYNC_BYTE) begin
               sel_two_nxt = 1'b1;
               baud_start = 1'b1;
               st_nxt = ST_BAUD;
            end
         end
         ST_BAUD: begin
            if (baud_done) begin
               tx_valid = 1'b1;
               st_nxt = ST_CMD;
            end
         end
         ST_CMD: begin
            if (rx_v) begin
               cmd_nxt = rx_d;
               st_nxt = ST_CHK;
            end
         end
         ST_CHK: begin
            if (rx_v) begin
               if (!known_cmd || rx_d != ~cmd_r) begin
                  tx_valid = 1'b1;
                  tx_data = boot_sel_pkg::NACK_BYTE;
                  st_nxt = ST_CMD;
               end else begin
                  tx_valid = 1'b1;
                  st_nxt = (cmd_r == boot_sel_pkg::CMD_READ
                     || is_wr || cmd_r == boot_sel_pkg::CMD_ERASE)
                     ? ST_ADDR : ST_MEM;
               end
            end
         end
         ST_ADDR: begin
            // address and count arrive assembled from the byte decoder
            if (rx_v) begin
               if (!acc_sup || !acc_align
                     || (cmd_r == boot_sel_pkg::CMD_ERASE && acc_data)) begin
                  tx_valid = !SILENT_ABORT;
                  tx_data = boot_sel_pkg::NACK_BYTE;
                  st_nxt = SILENT_ABORT ? ST_CHK : ST_CMD;
                  cmd_nxt = rx_d;
               end else begin
                  tx_valid = 1'b1;
                  mem_op_valid = 1'b1;
                  st_nxt = ST_CMD;
                  if (cmd_r == boot_sel_pkg::CMD_READ)
                     mem_op = boot_sel_pkg::MOP_READ;
                  else if (cmd_r == boot_sel_pkg::CMD_ERASE)
                     mem_op = boot_sel_pkg::MOP_PAGE_ERASE;
                  else if (acc_data) begin
                     mem_op = boot_sel_pkg::MOP_DATA_ERASE;
                     data_prog_nxt = 1'b1;
                  end else if (acc_flash)
                     mem_op = boot_sel_pkg::MOP_HALF_PAGE;
                  else
                     mem_op = boot_sel_pkg::MOP_DATA_PROG;
               end
            end
         end
         ST_MEM: begin
            tx_valid = 1'b1;
            st_nxt = ST_CMD;
            if (cmd_r == boot_sel_pkg::CMD_RD_PROT)
               prot_nxt = boot_sel_pkg::PROT_L1;
            else if (cmd_r == boot_sel_pkg::CMD_RD_UNPROT) begin
               if (prot_r == boot_sel_pkg::PROT_L1) begin
                  mem_op_valid = 1'b1;
                  mem_op = boot_sel_pkg::MOP_MASS_ERASE;
                  mem_addr = boot_sel_pkg::FLASH_LO;
               end
               prot_nxt = boot_sel_pkg::PROT_L0;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      // the data program step always follows its own erase, at its address
      prog_addr_nxt = data_prog_nxt ? cmd_addr : prog_addr_r;
      if (data_prog_r) begin
         mem_op_valid = 1'b1;
         mem_op = boot_sel_pkg::MOP_DATA_PROG;
         mem_addr = prog_addr_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= ST_IDLE;
         sel_two_r <= 1'b0;
         cmd_r <= 8'h00;
         prot_r <= boot_sel_pkg::PROT_L0;
         prot_init_r <= 1'b0;
         data_prog_r <= 1'b0;
         prog_addr_r <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
         sel_two_r <= sel_two_nxt;
         cmd_r <= cmd_nxt;
         prot_r <= prot_nxt;
         prot_init_r <= prot_init_nxt;
         data_prog_r <= data_prog_nxt;
         prog_addr_r <= prog_addr_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   logic in_session;
   always_comb begin
      in_session = st_r != ST_IDLE && st_r != ST_DETECT;
      boot_space = space_r;
      cpu_halt = halt_r;
      loader_active = st_r != ST_IDLE;
      port_one_enable = st_r == ST_DETECT || (in_session && !sel_two_r);
      port_two_enable = st_r == ST_DETECT || (in_session && sel_two_r);
      prot_level_out = prot_r;
   end

endmodule // boot_space_select_loader

// ### boot_sel_pkg.sv
// package: constants for the boot space selector and serial loader model
// assumes: included first in compile order; no other dependencies
package boot_sel_pkg;

   // ------------------------------------------------------------
   // sync and answer bytes
   // ------------------------------------------------------------
   localparam logic [7:0] SYNC_BYTE = 8'h7f;
   localparam logic [7:0] ACK_BYTE = 8'h79;
   localparam logic [7:0] NACK_BYTE = 8'h1f;

   // ------------------------------------------------------------
   // loader command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_GET = 8'h00;
   localparam logic [7:0] CMD_GET_VER = 8'h01;
   localparam logic [7:0] CMD_GET_ID = 8'h02;
   localparam logic [7:0] CMD_READ = 8'h11;
   localparam logic [7:0] CMD_GO = 8'h21;
   localparam logic [7:0] CMD_WRITE = 8'h31;
   localparam logic [7:0] CMD_ERASE = 8'h43;
   localparam logic [7:0] CMD_EXT_ERASE = 8'h44;
   localparam logic [7:0] CMD_WR_PROT = 8'h63;
   localparam logic [7:0] CMD_WR_UNPROT = 8'h73;
   localparam logic [7:0] CMD_RD_PROT = 8'h82;
   localparam logic [7:0] CMD_RD_UNPROT = 8'h92;

   // ------------------------------------------------------------
   // memory map
   // ------------------------------------------------------------
   localparam logic [31:0] FLASH_LO = 32'h0800_0000;
   localparam logic [31:0] FLASH_HI = 32'h0805_ffff;
   localparam logic [31:0] BANK1_BASE = 32'h0800_0000;
   localparam logic [31:0] BANK2_BASE = 32'h0803_0000;
   localparam logic [31:0] DATA_LO = 32'h0808_0000;
   localparam logic [31:0] DATA_HI = 32'h0808_0fff;
   localparam logic [31:0] SRAM_LO = 32'h2000_0000;
   localparam logic [31:0] SRAM_HI = 32'h2000_bfff;
   localparam logic [31:0] SYSMEM_LO = 32'h1ff0_0000;
   localparam logic [31:0] SYSMEM_HI = 32'h1ff0_1fff;
   localparam logic [31:0] OPT_LO = 32'h1ff8_0000;
   localparam logic [31:0] OPT_HI = 32'h1ff8_00ff;
   localparam logic [31:0] USER_OPT_ADDR = 32'h1ff8_0004;
   localparam int BANK_TWO_BIT_POS = 7;
   localparam logic [1:0] ALIGN_MASK = 2'h3;

   // ------------------------------------------------------------
   // boot space and protection encodings
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SPACE_BANK1 = 3'h0,
      SPACE_BANK2 = 3'h1,
      SPACE_SYSMEM = 3'h2,
      SPACE_SRAM = 3'h3,
      SPACE_HALT = 3'h4
   } boot_space_t;

   localparam logic [1:0] PROT_L0 = 2'h0;
   localparam logic [1:0] PROT_L1 = 2'h1;
   localparam logic [1:0] PROT_L2 = 2'h2;

   // ------------------------------------------------------------
   // memory operation codes toward the flash controller
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MOP_NONE = 3'h0,
      MOP_READ = 3'h1,
      MOP_HALF_PAGE = 3'h2,
      MOP_DATA_ERASE = 3'h3,
      MOP_DATA_PROG = 3'h4,
      MOP_PAGE_ERASE = 3'h5,
      MOP_MASS_ERASE = 3'h6
   } mem_op_t;

endpackage

// ### access_check.sv
// module: classifies a loader memory access against the memory map
// assumes: combinational; caller uses the outputs unregistered in its next-state logic
`timescale 1ns/1ps
module access_check (
   input wire logic [31:0] addr,
   input wire logic [7:0] count_m1,
   input wire logic is_write,
   output logic supported,
   output logic aligned_ok,
   output logic in_data,
   output logic in_flash
);
   logic [8:0] nbytes;

   always_comb begin
      nbytes = {1'b0, count_m1} + 9'h001;
      in_flash = addr >= boot_sel_pkg::FLASH_LO
         && addr <= boot_sel_pkg::FLASH_HI;
      in_data = addr >= boot_sel_pkg::DATA_LO
         && addr <= boot_sel_pkg::DATA_HI;
      supported = in_flash || in_data
         || (addr >= boot_sel_pkg::SRAM_LO && addr <= boot_sel_pkg::SRAM_HI)
         || (addr >= boot_sel_pkg::SYSMEM_LO
            && addr <= boot_sel_pkg::SYSMEM_HI)
         || (addr >= boot_sel_pkg::OPT_LO && addr <= boot_sel_pkg::OPT_HI);
      // flash and data writes are word aligned and whole words
      aligned_ok = !is_write || !(in_flash || in_data)
         || ((addr[1:0] & boot_sel_pkg::ALIGN_MASK) == 2'h0
            && (nbytes[1:0] & boot_sel_pkg::ALIGN_MASK) == 2'h0);
   end
endmodule // access_check

// ### boot_space_select_loader_chk.sv
// checker: port timing relations of the boot selector and loader
// assumes: bound to the top module; one clock, sync active-high reset
`timescale 1ns/1ps
module boot_space_select_loader_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic port_one_rx_valid,
   input wire logic [7:0] port_one_rx_data,
   input wire logic port_two_rx_valid,
   input wire logic [7:0] port_two_rx_data,
   input wire logic [2:0] boot_space,
   input wire logic cpu_halt,
   input wire logic loader_active,
   input wire logic port_one_enable,
   input wire logic port_two_enable,
   input wire logic baud_start,
   input wire logic mem_op_valid,
   input wire logic [2:0] mem_op,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0] prot_level_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // cycles since reset release, saturating
   logic [3:0] up_cnt_r;
   logic [3:0] up_cnt_nxt;
   always_comb begin
      up_cnt_nxt = up_cnt_r;
      if (rst) up_cnt_nxt = 4'h0;
      else if (up_cnt_r != 4'hf) up_cnt_nxt = up_cnt_r + 4'h1;
   end
   always_ff @(posedge clk) begin
      up_cnt_r <= up_cnt_nxt;
   end
   property p_detect;
      $rose(loader_active) |-> port_one_enable && port_two_enable;
   endproperty
   a_detect: assert property (p_detect) else $error("detect");
   property p_sync;
      baud_start |-> (port_one_enable && port_one_rx_valid &&
         port_one_rx_data == boot_sel_pkg::SYNC_BYTE) ||
         (port_two_enable && port_two_rx_valid &&
         port_two_rx_data == boot_sel_pkg::SYNC_BYTE);
   endproperty
   a_sync: assert property (p_sync) else $error("sync");
   property p_one_off;
      loader_active && port_two_enable && !port_one_enable |=>
         !port_one_enable;
   endproperty
   a_one_off: assert property (p_one_off) else $error("port");
   property p_data_seq;
      mem_op_valid && mem_op == boot_sel_pkg::MOP_DATA_ERASE |=>
         mem_op_valid && mem_op == boot_sel_pkg::MOP_DATA_PROG &&
         $stable(mem_addr);
   endproperty
   a_data_seq: assert property (p_data_seq) else $error("dseq");
   property p_half;
      mem_op_valid && mem_op == boot_sel_pkg::MOP_HALF_PAGE |->
         mem_addr[1:0] == 2'h0 && mem_addr >= boot_sel_pkg::FLASH_LO &&
         mem_addr <= boot_sel_pkg::FLASH_HI;
   endproperty
   a_half: assert property (p_half) else $error("half");
   property p_no_derase;
      mem_op_valid && mem_op == boot_sel_pkg::MOP_PAGE_ERASE |->
         !(mem_addr >= boot_sel_pkg::DATA_LO &&
         mem_addr <= boot_sel_pkg::DATA_HI);
   endproperty
   a_no_derase: assert property (p_no_derase)
      else $error("erase");
   property p_mass;
      mem_op_valid && mem_op == boot_sel_pkg::MOP_MASS_ERASE |->
         ##[0:3] prot_level_out == boot_sel_pkg::PROT_L0;
   endproperty
   a_mass: assert property (p_mass) else $error("mass");
   property p_halt;
      cpu_halt |-> boot_space == boot_sel_pkg::SPACE_SYSMEM && !loader_active;
   endproperty
   a_halt: assert property (p_halt) else $error("halt");
   property p_loader;
      loader_active |-> boot_space == boot_sel_pkg::SPACE_SYSMEM && !cpu_halt;
   endproperty
   a_loader: assert property (p_loader) else $error("loader");
   property p_frozen;
      up_cnt_r >= 4'h6 |-> $stable(boot_space) && $stable(cpu_halt);
   endproperty
   a_frozen: assert property (p_frozen) else $error("frozen");
endmodule // boot_space_select_loader_chk
bind boot_space_select_loader boot_space_select_loader_chk chk_i (
   .clk(clk), .rst(rst), .port_one_rx_valid(port_one_rx_valid),
   .port_one_rx_data(port_one_rx_data), .port_two_rx_valid(port_two_rx_valid),
   .port_two_rx_data(port_two_rx_data), .boot_space(boot_space),
   .cpu_halt(cpu_halt), .loader_active(loader_active),
   .port_one_enable(port_one_enable), .port_two_enable(port_two_enable),
   .baud_start(baud_start), .mem_op_valid(mem_op_valid), .mem_op(mem_op),
   .mem_addr(mem_addr), .prot_level_out(prot_level_out)
);

// ### host_prog_model.sv
// model: host programmer feeding the two receive byte streams
// assumes: the bench calls its tasks; inputs change at falling edges
`timescale 1ns/1ps
module host_prog_model (
   input wire logic clk,
   output logic port_one_rx_valid,
   output logic [7:0] port_one_rx_data,
   output logic port_two_rx_valid,
   output logic [7:0] port_two_rx_data,
   output logic baud_done,
   output logic [31:0] cmd_addr,
   output logic [7:0] cmd_count_m1
);
   initial begin
      port_one_rx_valid = 1'b0;
      port_two_rx_valid = 1'b0;
      port_one_rx_data = 8'h00;
      port_two_rx_data = 8'h00;
      baud_done = 1'b0;
      cmd_addr = 32'h0;
      cmd_count_m1 = 8'h0;
   end
   // one byte for one cycle; afterwards data shows its inverse
   task automatic send(input bit two, input logic [7:0] b,
         input logic [31:0] a = 32'h0, input logic [7:0] n = 8'h0);
      @(negedge clk);
      cmd_addr = a;
      cmd_count_m1 = n;
      if (two) begin
         port_two_rx_valid = 1'b1;
         port_two_rx_data = b;
      end else begin
         port_one_rx_valid = 1'b1;
         port_one_rx_data = b;
      end
      @(negedge clk);
      port_one_rx_valid = 1'b0;
      port_two_rx_valid = 1'b0;
      port_one_rx_data = ~port_one_rx_data;
      port_two_rx_data = ~port_two_rx_data;
      cmd_addr = ~cmd_addr;
   endtask
   task automatic baud();
      @(negedge clk);
      baud_done = 1'b1;
      @(negedge clk);
      baud_done = 1'b0;
   endtask
endmodule // host_prog_model

// ### boot_space_select_loader_bench.sv
// bench: boot choice table and a loader session on port two
// assumes: package, design, checker and host model compiled first
`timescale 1ns/1ps
module boot_space_select_loader_bench;
   localparam logic [7:0] ack = boot_sel_pkg::ACK_BYTE;
   localparam logic [7:0] nak = boot_sel_pkg::NACK_BYTE;
   localparam logic [31:0] vw = boot_sel_pkg::SRAM_LO;
   localparam logic [31:0] iw = boot_sel_pkg::SRAM_HI + 32'h1;
   localparam logic [31:0] dlo = boot_sel_pkg::DATA_LO;
   localparam logic [2:0] b1 = boot_sel_pkg::SPACE_BANK1;
   localparam logic [2:0] b2 = boot_sel_pkg::SPACE_BANK2;
   localparam logic [2:0] sm = boot_sel_pkg::SPACE_SYSMEM;
   localparam logic [2:0] sr = boot_sel_pkg::SPACE_SRAM;
   localparam logic [2:0] mass = boot_sel_pkg::MOP_MASS_ERASE;
   logic clk, rst, primary_boot_pin, secondary_boot_pin, baud_done;
   logic [7:0] user_option_byte, port_one_rx_data, port_two_rx_data;
   logic [7:0] cmd_count_m1, tx_data;
   logic [1:0] prot_level_in, prot_level_out, ens;
   logic [31:0] bank1_first_word, bank2_first_word, cmd_addr, mem_addr;
   logic [31:0] last_addr;
   logic port_one_rx_valid, port_two_rx_valid, cpu_halt, loader_active;
   logic port_one_enable, port_two_enable, baud_start, tx_valid;
   logic mem_op_valid;
   logic [2:0] boot_space, mem_op;
   logic [7:0] tx_q[$];
   logic [2:0] op_q[$];
   int n_errors, checks_done, n_baud;
   assign ens = {port_one_enable, port_two_enable};
   boot_space_select_loader dut (
      .clk(clk), .rst(rst), .primary_boot_pin(primary_boot_pin),
      .secondary_boot_pin(secondary_boot_pin),
      .user_option_byte(user_option_byte), .prot_level_in(prot_level_in),
      .bank1_first_word(bank1_first_word),
      .bank2_first_word(bank2_first_word),
      .port_one_rx_valid(port_one_rx_valid),
      .port_one_rx_data(port_one_rx_data),
      .port_two_rx_valid(port_two_rx_valid),
      .port_two_rx_data(port_two_rx_data), .baud_done(baud_done),
      .cmd_addr(cmd_addr), .cmd_count_m1(cmd_count_m1),
      .boot_space(boot_space), .cpu_halt(cpu_halt),
      .loader_active(loader_active), .port_one_enable(port_one_enable),
      .port_two_enable(port_two_enable), .baud_start(baud_start),
      .tx_valid(tx_valid), .tx_data(tx_data), .mem_op_valid(mem_op_valid),
      .mem_op(mem_op), .mem_addr(mem_addr), .prot_level_out(prot_level_out)
   );
   host_prog_model hp (
      .clk(clk), .port_one_rx_valid(port_one_rx_valid),
      .port_one_rx_data(port_one_rx_data),
      .port_two_rx_valid(port_two_rx_valid),
      .port_two_rx_data(port_two_rx_data), .baud_done(baud_done),
      .cmd_addr(cmd_addr), .cmd_count_m1(cmd_count_m1)
   );
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // collect answers and memory operations as they pulse
   always @(posedge clk) begin
      if (tx_valid === 1'b1) tx_q.push_back(tx_data);
      if (mem_op_valid === 1'b1) op_q.push_back(mem_op);
      if (mem_op_valid === 1'b1) last_addr = mem_addr;
      if (baud_start === 1'b1) n_baud++;
   end
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [2:0] pop_op();
      return op_q.size() > 0 ? op_q.pop_front() : boot_sel_pkg::MOP_NONE;
   endfunction
   task automatic txe(input logic [7:0] e);
      logic [7:0] g;
      g = 8'hxx;
      if (tx_q.size() > 0) g = tx_q.pop_front();
      chk("tx_data", 32'(e), 32'(g));
   endtask
   // straps held steady through reset, then checked after the decision
   task automatic boot(input logic [7:0] ob, input logic [1:0] pins,
         input logic [1:0] pl, input logic [31:0] w1, input logic [31:0] w2,
         input logic [2:0] es, input logic eh);
      rst = 1'b1;
      user_option_byte = ob;
      primary_boot_pin = pins[1];
      secondary_boot_pin = pins[0];
      prot_level_in = pl;
      bank1_first_word = w1;
      bank2_first_word = w2;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      chk("boot_space", 32'(es), 32'(boot_space));
      chk("cpu_halt", 32'(eh), 32'(cpu_halt));
      tx_q.delete();
      op_q.delete();
      n_baud = 0;
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] e);
      hp.send(1'b1, c);
      hp.send(1'b1, ~c);
      repeat (2) @(negedge clk);
      txe(e);
   endtask
   task automatic acc(input logic [7:0] c, input logic [31:0] a,
         input logic [7:0] n, input logic [7:0] et, input logic [5:0] eo);
      cmd(c, ack);
      hp.send(1'b1, n, a, n);
      repeat (3) @(negedge clk);
      txe(et);
      chk("first op", 32'(eo[2:0]), 32'(pop_op()));
      chk("second op", 32'(eo[5:3]), 32'(pop_op()));
      if (eo != 6'h00) chk("mem_addr", a, last_addr);
      tx_q.delete();
   endtask
   task automatic t_boot;
      boot(8'h80, 2'h0, 2'h0, iw, iw, b1, 1'b0);
      boot(8'h80, 2'h2, 2'h2, vw, vw, b1, 1'b0);
      boot(8'h80, 2'h3, 2'h0, iw, iw, sr, 1'b0);
      primary_boot_pin = 1'b0;
      user_option_byte = 8'h7f;
      repeat (8) @(negedge clk);
      chk("frozen", 32'(sr), 32'(boot_space));
      boot(8'h7f, 2'h0, 2'h0, vw, vw, b2, 1'b0);
      boot(8'h7f, 2'h1, 2'h0, vw, 32'h1fff_ffff, b1, 1'b0);
      boot(8'h7f, 2'h0, 2'h0, 32'h0, 32'h0, sm, 1'b0);
      chk("loader_active", 32'h1, 32'(loader_active));
      boot(8'h7f, 2'h3, 2'h2, iw, iw, sm, 1'b1);
      boot(8'h7f, 2'h3, 2'h2, vw, iw, b1, 1'b0);
      boot(8'h7f, 2'h3, 2'h0, vw, vw, sr, 1'b0);
   endtask
   task automatic t_session;
      boot(8'h80, 2'h2, 2'h0, vw, vw, sm, 1'b0);
      chk("enables", 32'h3, 32'(ens));
      hp.send(1'b0, 8'h55);
      hp.send(1'b1, 8'h7f);
      chk("baud_start", 32'h1, 32'(n_baud));
      hp.baud();
      txe(ack);
      chk("enables", 32'h1, 32'(ens));
      hp.send(1'b0, 8'h7f);
      hp.send(1'b0, 8'h00);
      chk("tx count", 32'h0, 32'(tx_q.size()));
      chk("baud_start", 32'h1, 32'(n_baud));
   endtask
   task automatic t_cmds;
      logic [7:0] oc [7];
      oc = '{8'h00, 8'h01, 8'h02, 8'h44, 8'h63, 8'h73, 8'h82};
      cmd(8'h03, nak);
      hp.send(1'b1, 8'h00);
      hp.send(1'b1, 8'h00);
      txe(nak);
      foreach (oc[i]) begin
         cmd(oc[i], ack);
         repeat (4) @(negedge clk);
         tx_q.delete();
         op_q.delete();
      end
      chk("prot", 32'h1, 32'(prot_level_out));
      cmd(8'h92, ack);
      repeat (4) @(negedge clk);
      chk("prot", 32'h0, 32'(prot_level_out));
      chk("mass", 32'(mass), 32'(pop_op()));
      chk("mass addr", boot_sel_pkg::FLASH_LO, last_addr);
      tx_q.delete();
   endtask
   task automatic t_mem;
      acc(8'h11, dlo, 8'h03, ack, 6'h01);
      acc(8'h11, 32'h0808_0ffc, 8'h03, ack, 6'h01);
      acc(8'h11, 32'h0808_1000, 8'h03, nak, 6'h00);
      acc(8'h11, 32'h6000_0000, 8'h03, nak, 6'h00);
      acc(8'h31, dlo, 8'h03, ack, 6'h23);
      acc(8'h31, dlo + 32'h2, 8'h03, nak, 6'h00);
      acc(8'h31, dlo, 8'h04, nak, 6'h00);
      acc(8'h31, 32'h0800_0104, 8'h07, ack, 6'h02);
      acc(8'h31, 32'h0800_0102, 8'h03, nak, 6'h00);
      acc(8'h43, dlo, 8'h00, nak, 6'h00);
      cmd(8'h21, ack);
   endtask
   task automatic end_sim;
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      t_boot;
      t_session;
      t_cmds;
      t_mem;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim;
   end
endmodule // boot_space_select_loader_bench
